// ### verilog/pc_palette_cursor.sv
// Palette, cursor colours, cursor position and cursor image fetch
`timescale 1ns/1ns
module pc_palette_cursor (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rst,
	input  wire pc_pkg::pc_reg_req_s   i_reg,
	output logic [7:0]                 o_reg_rdata,
	output logic                       o_reg_rvalid,
	input  wire logic                  i_frame_start,
	input  wire logic                  i_line_start,
	input  wire logic [11:0]           i_line_y,
	input  wire logic [23:10]          i_cursor_image_base,
	output logic                       o_fetch_req,
	output logic [23:0]                o_fetch_addr,
	input  wire logic                  i_fetch_ack,
	input  wire logic [63:0]           i_fetch_data,
	input  wire pc_pkg::pc_pix_s       i_pix,
	output logic [23:0]                o_pix_rgb,
	output logic                       o_pix_valid
);
	import pc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  wr_idx;
		logic [7:0]  rd_idx;
		logic [7:0]  cwr_idx;
		logic [7:0]  crd_idx;
		logic [7:0]  mask;
		logic [7:0]  cmd0;
		logic [7:0]  cmd1;
		logic [7:0]  cmd2;
		logic [1:0]  comp;
		logic        dir;
		logic [7:0]  red_acc;
		logic [7:0]  grn_acc;
		logic [7:0]  x_lo;
		logic [3:0]  x_hi;
		logic [7:0]  y_lo;
		logic [3:0]  y_hi;
		logic [11:0] pos_x;
		logic [11:0] pos_y;
		logic [11:0] fr_x;
		logic [11:0] fr_y;
		pc_fetch_e   fst;
		logic        line_hit;
		logic [63:0] plane0;
		logic [63:0] plane1;
		logic        fetch_req;
		logic [23:0] fetch_addr;
		logic [7:0]  rdata;
		logic        rvalid;
		logic [23:0] pix_rgb;
		logic        pix_valid;
	} pc_state_s;

	pc_state_s   q;
	pc_state_s   d;
	logic [23:0] pal_mem [256];
	logic [23:0] cc_mem  [4];
	logic        pal_we;
	logic [7:0]  pal_waddr;
	logic [23:0] pal_wdata;
	logic        cc_we;
	logic [1:0]  cc_waddr;
	logic [23:0] cc_wdata;
	logic [9:0]  key;
	logic        ext_reg;

	function automatic logic [7:0] comp_byte(input logic [23:0] c,
		input logic [1:0] k);
		if (k == COMP_RED) begin
			return c[23:16];
		end else if (k == COMP_GREEN) begin
			return c[15:8];
		end
		return c[7:0];
	endfunction

	// ------------------------------------------------------------
	// Address normalisation
	// ------------------------------------------------------------
	// Legacy ports other than LEG_STATE fold onto offsets so one decoder serves both
	always_comb begin
		ext_reg = (i_reg.addr >= OFF_PAL_RD_IDX) &&
			(i_reg.addr <= OFF_CUR_Y_HI) && (i_reg.addr != OFF_PWR_RES);
		if (i_reg.io) begin
			if (i_reg.addr == LEG_PAL_WR_IDX) begin
				key = OFF_PAL_WR_IDX;
			end else if (i_reg.addr == LEG_PAL_DATA) begin
				key = OFF_PAL_DATA;
			end else if (i_reg.addr == LEG_PIX_MASK) begin
				key = OFF_PIX_MASK;
			end else if (i_reg.addr == LEG_STATE) begin
				key = LEG_STATE;
			end else begin
				key = KEY_NONE;
			end
		end else if (ext_reg && !q.cmd0[EXT_EN_BIT]) begin
			key = KEY_NONE;
		end else begin
			key = i_reg.addr;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [23:0] base;
		logic [12:0] row;
		logic [12:0] col;
		logic [7:0]  idx8;
		logic        p0;
		logic        p1;
		logic        in_cur;
		logic [23:0] rgb;
		d = q;
		base = 24'h000000;
		row = 13'h0000;
		col = 13'h0000;
		idx8 = 8'h00;
		p0 = 1'b0;
		p1 = 1'b0;
		in_cur = 1'b0;
		rgb = 24'h000000;
		pal_we = 1'b0;
		pal_waddr = q.wr_idx;
		pal_wdata = 24'h000000;
		cc_we = 1'b0;
		cc_waddr = q.cwr_idx[1:0];
		cc_wdata = 24'h000000;
		d.rvalid = i_reg.rd;
		d.rdata = 8'h00;

		// Register writes
		if (i_reg.wr) begin
			if (key == OFF_PAL_WR_IDX) begin
				d.wr_idx = i_reg.wdata[7:0];
				d.comp = COMP_RED;
			end else if (key == OFF_PAL_DATA && i_reg.word) begin
				pal_we = 1'b1;
				pal_wdata = i_reg.wdata;
				d.wr_idx = q.wr_idx + 8'h01;
				d.comp = COMP_RED;
				d.dir = 1'b0;
			end else if (key == OFF_PAL_DATA) begin
				d.dir = 1'b0;
				if (q.comp == COMP_RED) begin
					d.red_acc = i_reg.wdata[7:0];
					d.comp = COMP_GREEN;
				end else if (q.comp == COMP_GREEN) begin
					d.grn_acc = i_reg.wdata[7:0];
					d.comp = COMP_BLUE;
				end else begin
					pal_we = 1'b1;
					pal_wdata = {q.red_acc, q.grn_acc, i_reg.wdata[7:0]};
					d.wr_idx = q.wr_idx + 8'h01;
					d.comp = COMP_RED;
				end
			end else if (key == OFF_PIX_MASK) begin
				d.mask = i_reg.wdata[7:0];
			end else if (key == OFF_PAL_RD_IDX || key == LEG_STATE) begin
				d.rd_idx = i_reg.wdata[7:0];
				d.comp = COMP_RED;
			end else if (key == OFF_CC_WR_IDX) begin
				d.cwr_idx = i_reg.wdata[7:0];
				d.comp = COMP_RED;
			end else if (key == OFF_CC_DATA) begin
				if (q.comp == COMP_RED) begin
					d.red_acc = i_reg.wdata[7:0];
					d.comp = COMP_GREEN;
				end else if (q.comp == COMP_GREEN) begin
					d.grn_acc = i_reg.wdata[7:0];
					d.comp = COMP_BLUE;
				end else begin
					cc_we = 1'b1;
					cc_wdata = {q.red_acc, q.grn_acc, i_reg.wdata[7:0]};
					d.cwr_idx = q.cwr_idx + 8'h01;
					d.comp = COMP_RED;
				end
			end else if (key == OFF_PWR_RES) begin
				d.cmd0 = i_reg.wdata[7:0];
			end else if (key == OFF_CC_RD_IDX) begin
				d.crd_idx = i_reg.wdata[7:0];
				d.comp = COMP_RED;
			end else if (key == OFF_PIXMODE) begin
				d.cmd1 = i_reg.wdata[7:0];
			end else if (key == OFF_CUR_IDX) begin
				d.cmd2 = i_reg.wdata[7:0];
			end else if (key == OFF_CUR_X_LO) begin
				d.x_lo = i_reg.wdata[7:0];
			end else if (key == OFF_CUR_X_HI) begin
				d.x_hi = i_reg.wdata[3:0];
			end else if (key == OFF_CUR_Y_LO) begin
				d.y_lo = i_reg.wdata[7:0];
			end else if (key == OFF_CUR_Y_HI) begin
				d.y_hi = i_reg.wdata[3:0];
				d.pos_x = {q.x_hi, q.x_lo};
				d.pos_y = {i_reg.wdata[3:0], q.y_lo};
			end
		end

		// Register reads
		if (i_reg.rd) begin
			if (key == OFF_PAL_WR_IDX) begin
				d.rdata = q.wr_idx;
			end else if (key == OFF_PAL_DATA) begin
				d.rdata = comp_byte(pal_mem[q.rd_idx], q.comp);
				d.dir = 1'b1;
				d.comp = (q.comp == COMP_BLUE) ? COMP_RED
					: q.comp + 2'h1;
				if (q.comp == COMP_BLUE) begin
					d.rd_idx = q.rd_idx + 8'h01;
				end
			end else if (key == OFF_PIX_MASK) begin
				d.rdata = q.mask;
			end else if (key == LEG_STATE) begin
				d.rdata = q.dir ? LEG_OP_READ : LEG_OP_WRITE;
			end else if (key == OFF_PAL_RD_IDX) begin
				d.rdata = q.rd_idx;
			end else if (key == OFF_CC_WR_IDX) begin
				d.rdata = q.cwr_idx;
			end else if (key == OFF_CC_DATA) begin
				d.rdata = comp_byte(cc_mem[q.crd_idx[1:0]], q.comp);
				d.comp = (q.comp == COMP_BLUE) ? COMP_RED
					: q.comp + 2'h1;
				if (q.comp == COMP_BLUE) begin
					d.crd_idx = q.crd_idx + 8'h01;
				end
			end else if (key == OFF_PWR_RES) begin
				d.rdata = q.cmd0;
			end else if (key == OFF_CC_RD_IDX) begin
				d.rdata = q.crd_idx;
			end else if (key == OFF_PIXMODE) begin
				d.rdata = q.cmd1;
			end else if (key == OFF_CUR_IDX) begin
				d.rdata = q.cmd2;
			end else if (key == OFF_STATE_RPT) begin
				d.rdata = {STATUS_ID, STATUS_REV, 1'b0, q.dir, q.comp};
			end else if (key == OFF_LAST_DIR) begin
				d.rdata = {7'h00, q.dir};
			end else if (key == OFF_CUR_X_LO) begin
				d.rdata = q.x_lo;
			end else if (key == OFF_CUR_X_HI) begin
				d.rdata = {4'h0, q.x_hi};
			end else if (key == OFF_CUR_Y_LO) begin
				d.rdata = q.y_lo;
			end else if (key == OFF_CUR_Y_HI) begin
				d.rdata = {4'h0, q.y_hi};
			end
		end

		// Frame position latch
		if (i_frame_start) begin
			d.fr_x = q.pos_x;
			d.fr_y = q.pos_y;
		end

		// Cursor image fetch, two plane words per cursor line
		case (q.fst)
			FETCH_IDLE: begin
				if (i_line_start) begin
					row = {1'b0, i_line_y} + CUR_SIZE - {1'b0, q.fr_y};
					d.line_hit = (row < CUR_SIZE) &&
						(q.cmd2[CMODE_LSB+:2] != CUR_OFF) &&
						!(q.fr_x == 12'h000 && q.fr_y == 12'h000);
					if (d.line_hit) begin
						d.fetch_req = 1'b1;
						d.fetch_addr = {i_cursor_image_base, ~row[5:0],
							PLANE0_OFF};
						d.fst = FETCH_PLANE0;
					end
				end
			end
			FETCH_PLANE0: begin
				if (i_fetch_ack) begin
					d.plane0 = i_fetch_data;
					d.fetch_addr = {q.fetch_addr[23:4], PLANE1_OFF};
					d.fst = FETCH_PLANE1;
				end
			end
			FETCH_PLANE1: begin
				if (i_fetch_ack) begin
					d.plane1 = i_fetch_data;
					d.fetch_req = 1'b0;
					d.fst = FETCH_IDLE;
				end
			end
			default: begin
				d.fst = FETCH_IDLE;
				d.fetch_req = 1'b0;
			end
		endcase

		// Pixel path
		idx8 = i_pix.data[7:0] & q.mask;
		if (q.cmd1[BYPASS_BIT]) begin
			base = i_pix.data;
		end else if (q.cmd1[PIXMODE_LSB+:2] == PIX_8BPP) begin
			base = pal_mem[idx8];
		end else begin
			base = {pal_mem[i_pix.data[23:16] & q.mask][23:16],
				pal_mem[i_pix.data[15:8] & q.mask][15:8],
				pal_mem[idx8][7:0]};
		end
		col = {1'b0, i_pix.x} + CUR_SIZE - {1'b0, q.fr_x};
		in_cur = q.line_hit && (col < CUR_SIZE);
		p0 = q.plane0[~col[5:0]];
		p1 = q.plane1[~col[5:0]];
		rgb = base;
		if (in_cur) begin
			case (q.cmd2[CMODE_LSB+:2])
				CUR_THREE: begin
					if (p1 || p0) begin
						rgb = cc_mem[{p1, p0}];
					end
				end
				CUR_HILITE: begin
					if (p1 && p0) begin
						rgb = ~base;
					end else if (p1 || p0) begin
						rgb = cc_mem[{p1, p0}];
					end
				end
				CUR_XWIN: begin
					if (p1) begin
						rgb = cc_mem[{1'b0, p0} + 2'h1];
					end
				end
				default: begin
					rgb = base;
				end
			endcase
		end
		// 6-bit mode: the low six bits of each component move to the top six bits
		if (!q.cmd0[RES8_BIT]) begin
			rgb = {rgb[21:16], 2'h0, rgb[13:8], 2'h0, rgb[5:0], 2'h0};
		end
		d.pix_rgb = q.cmd0[PWR_DOWN_BIT] ? 24'h000000 : rgb;
		d.pix_valid = i_pix.valid;
	end

	// ------------------------------------------------------------
	// Registers and memories
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
			q.fst <= FETCH_IDLE;
		end else begin
			q <= d;
		end
	end

	// Colour memories are not reset; software loads them
	always_ff @(posedge i_ref_clk) begin
		if (pal_we) begin
			pal_mem[pal_waddr] <= pal_wdata;
		end
		if (cc_we) begin
			cc_mem[cc_waddr] <= cc_wdata;
		end
	end

	assign o_reg_rdata  = q.rdata;
	assign o_reg_rvalid = q.rvalid;
	assign o_fetch_req  = q.fetch_req;
	assign o_fetch_addr = q.fetch_addr;
	assign o_pix_rgb    = q.pix_rgb;
	assign o_pix_valid  = q.pix_valid;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_pos_hold;
		(i_reg.wr && (key == OFF_CUR_X_LO || key == OFF_CUR_X_HI ||
			key == OFF_CUR_Y_LO)) |=> $stable(q.pos_x) && $stable(q.pos_y);
	endproperty
	a_pos_hold: assert property (p_pos_hold)
		else $error("position changed before high Y write");

	property p_pos_commit;
		(i_reg.wr && key == OFF_CUR_Y_HI) |=>
			q.pos_y == {$past(i_reg.wdata[3:0]), $past(q.y_lo)} &&
			q.pos_x == {$past(q.x_hi), $past(q.x_lo)};
	endproperty
	a_pos_commit: assert property (p_pos_commit)
		else $error("position set not committed");

	property p_frame_hold;
		!i_frame_start |=> $stable(q.fr_x) && $stable(q.fr_y);
	endproperty
	a_frame_hold: assert property (p_frame_hold)
		else $error("frame position moved mid frame");

	property p_fetch_base;
		q.fetch_req |-> q.fetch_addr[23:10] == i_cursor_image_base &&
			q.fetch_addr[2:0] == 3'h0;
	endproperty
	a_fetch_base: assert property (p_fetch_base)
		else $error("fetch address outside cursor image");

	property p_plane_step;
		(q.fst == FETCH_PLANE0 && i_fetch_ack) |=>
			q.fetch_addr == $past(q.fetch_addr) + 24'h000008 && q.fetch_req;
	endproperty
	a_plane_step: assert property (p_plane_step)
		else $error("plane 1 not at plane 0 plus 8");

	property p_word_adv;
		(i_reg.wr && i_reg.word && key == OFF_PAL_DATA) |=>
			q.wr_idx == $past(q.wr_idx) + 8'h01;
	endproperty
	a_word_adv: assert property (p_word_adv)
		else $error("word write did not advance index");

	property p_byte_adv;
		(i_reg.wr && !i_reg.word && key == OFF_PAL_DATA &&
			q.comp == COMP_BLUE) |=>
			q.wr_idx == $past(q.wr_idx) + 8'h01 && q.comp == COMP_RED;
	endproperty
	a_byte_adv: assert property (p_byte_adv)
		else $error("blue byte did not advance index");

	property p_read_dir;
		(i_reg.rd && key == OFF_PAL_DATA) |=> q.dir && o_reg_rvalid;
	endproperty
	a_read_dir: assert property (p_read_dir)
		else $error("palette read not flagged");

	property p_legacy_state;
		(i_reg.rd && !i_reg.wr && key == LEG_STATE) |=>
			o_reg_rdata == ($past(q.dir) ? LEG_OP_READ : LEG_OP_WRITE);
	endproperty
	a_legacy_state: assert property (p_legacy_state)
		else $error("legacy state value wrong");

	property p_id_bits;
		(i_reg.rd && key == OFF_STATE_RPT) |=>
			o_reg_rdata[7:6] == STATUS_ID && !o_reg_rdata[3];
	endproperty
	a_id_bits: assert property (p_id_bits)
		else $error("identification bits wrong");

	property p_power_down;
		(i_pix.valid && q.cmd0[PWR_DOWN_BIT]) |=>
			o_pix_valid && o_pix_rgb == 24'h000000;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("output not blank in power down");

	property p_hidden;
		(i_line_start && q.fst == FETCH_IDLE && q.fr_x == 12'h000 &&
			q.fr_y == 12'h000) |=> !q.line_hit ##1 !q.fetch_req;
	endproperty
	a_hidden: assert property (p_hidden)
		else $error("cursor shown at position zero");

	c_word_load: cover property (i_reg.wr && i_reg.word &&
		key == OFF_PAL_DATA ##1 i_reg.wr && i_reg.word);
	c_full_fetch: cover property (q.fst == FETCH_PLANE1 && i_fetch_ack);
	c_legacy_read: cover property (i_reg.rd && key == LEG_STATE && q.dir);
	c_cursor_pixel: cover property (q.line_hit && i_pix.valid);

endmodule

// ### verilog/pc_pkg.sv
// Shared constants and carriers for the palette and cursor unit
package pc_pkg;

	// ------------------------------------------------------------
	// Register offsets, memory-mapped and legacy port space
	// ------------------------------------------------------------
	localparam logic [9:0] OFF_PAL_WR_IDX  = 10'h0B0;
	localparam logic [9:0] OFF_PAL_DATA    = 10'h0B1;
	localparam logic [9:0] OFF_PIX_MASK    = 10'h0B2;
	localparam logic [9:0] OFF_PAL_RD_IDX  = 10'h0B3;
	localparam logic [9:0] OFF_CC_WR_IDX   = 10'h0B4;
	localparam logic [9:0] OFF_CC_DATA     = 10'h0B5;
	localparam logic [9:0] OFF_PWR_RES     = 10'h0B6;
	localparam logic [9:0] OFF_CC_RD_IDX   = 10'h0B7;
	localparam logic [9:0] OFF_PIXMODE     = 10'h0B8;
	localparam logic [9:0] OFF_CUR_IDX     = 10'h0B9;
	localparam logic [9:0] OFF_STATE_RPT   = 10'h0BA;
	localparam logic [9:0] OFF_LAST_DIR    = 10'h0BB;
	localparam logic [9:0] OFF_CUR_X_LO    = 10'h0BC;
	localparam logic [9:0] OFF_CUR_X_HI    = 10'h0BD;
	localparam logic [9:0] OFF_CUR_Y_LO    = 10'h0BE;
	localparam logic [9:0] OFF_CUR_Y_HI    = 10'h0BF;
	localparam logic [9:0] LEG_PIX_MASK    = 10'h3C6;
	localparam logic [9:0] LEG_STATE       = 10'h3C7;
	localparam logic [9:0] LEG_PAL_WR_IDX  = 10'h3C8;
	localparam logic [9:0] LEG_PAL_DATA    = 10'h3C9;
	localparam logic [9:0] KEY_NONE        = 10'h3FF;

	// ------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------
	localparam int         PWR_DOWN_BIT    = 0;
	localparam int         RES8_BIT        = 1;
	localparam int         EXT_EN_BIT      = 2;
	localparam int         BYPASS_BIT      = 4;
	localparam int         PIXMODE_LSB     = 5;
	localparam int         CMODE_LSB       = 0;
	localparam int         CONTIG_BIT      = 2;
	localparam logic [1:0] PIX_32BPP       = 2'h0;
	localparam logic [1:0] PIX_16BPP       = 2'h1;
	localparam logic [1:0] PIX_8BPP        = 2'h2;
	localparam logic [1:0] CUR_OFF         = 2'h0;
	localparam logic [1:0] CUR_THREE       = 2'h1;
	localparam logic [1:0] CUR_HILITE      = 2'h2;
	localparam logic [1:0] CUR_XWIN        = 2'h3;
	localparam logic [1:0] COMP_RED        = 2'h0;
	localparam logic [1:0] COMP_GREEN      = 2'h1;
	localparam logic [1:0] COMP_BLUE       = 2'h2;
	localparam logic [1:0] STATUS_ID       = 2'h0;
	// Arbitrary revision value
	localparam logic [1:0] STATUS_REV      = 2'h1;
	localparam logic [7:0] LEG_OP_READ     = 8'h03;
	localparam logic [7:0] LEG_OP_WRITE    = 8'h00;
	localparam logic [12:0] CUR_SIZE       = 13'h0040;
	localparam logic [3:0] PLANE0_OFF      = 4'h0;
	localparam logic [3:0] PLANE1_OFF      = 4'h8;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        io;
		logic        word;
		logic [9:0]  addr;
		logic [23:0] wdata;
	} pc_reg_req_s;

	typedef struct packed {
		logic        valid;
		logic [11:0] x;
		logic [23:0] data;
	} pc_pix_s;

	typedef enum logic [1:0] {
		FETCH_IDLE,
		FETCH_PLANE0,
		FETCH_PLANE1
	} pc_fetch_e;

endpackage

// ### bench/test_pc_palette_cursor.sv
// Register-level bench for the palette and cursor unit
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end
module test_pc_palette_cursor;
	import pc_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic          clk;
	logic          rst;
	pc_reg_req_s   req;
	logic [7:0]    o_reg_rdata;
	logic          o_reg_rvalid;
	logic          frm;
	logic          lin;
	logic [11:0]   ly;
	logic [23:10]  base;
	logic          o_fetch_req;
	logic [23:0]   o_fetch_addr;
	logic          ack;
	logic [63:0]   fdat;
	pc_pix_s       pix;
	logic [23:0]   o_pix_rgb;
	logic          o_pix_valid;
	int            err_count;
	int            samples_checked;

	pc_palette_cursor dut (
		.i_ref_clk          (clk),
		.i_rst              (rst),
		.i_reg              (req),
		.o_reg_rdata        (o_reg_rdata),
		.o_reg_rvalid       (o_reg_rvalid),
		.i_frame_start      (frm),
		.i_line_start       (lin),
		.i_line_y           (ly),
		.i_cursor_image_base(base),
		.o_fetch_req        (o_fetch_req),
		.o_fetch_addr       (o_fetch_addr),
		.i_fetch_ack        (ack),
		.i_fetch_data       (fdat),
		.i_pix              (pix),
		.o_pix_rgb          (o_pix_rgb),
		.o_pix_valid        (o_pix_valid)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic wr(input logic io, input logic wd, input logic [9:0] a,
		input logic [23:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, io: io, word: wd, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask

	task automatic rd(input logic io, input logic [9:0] a,
		input logic [7:0] e, input string nm);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, io: io, word: 1'b0, addr: a, wdata: 24'h0};
		@(negedge clk);
		req = '0;
		`CHK(nm, {1'b1, e}, {o_reg_rvalid, o_reg_rdata})
	endtask

	task automatic px(input logic [11:0] x, input logic [23:0] d,
		input logic [23:0] e, input string nm);
		@(negedge clk);
		pix = '{valid: 1'b1, x: x, data: d};
		@(negedge clk);
		pix = '0;
		`CHK(nm, {1'b1, e}, {o_pix_valid, o_pix_rgb})
	endtask

	task automatic pulse(input logic f, input logic [11:0] y);
		@(negedge clk);
		frm = f;
		lin = ~f;
		ly = y;
		@(negedge clk);
		frm = 1'b0;
		lin = 1'b0;
	endtask

	// Plane 0 carries the leftmost and rightmost pixels, plane 1 is empty
	task automatic fetch(input logic [23:0] a, input string nm);
		int n;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			while (o_fetch_req !== 1'b1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			`CHK(nm, {1'b1, a + 24'(p * 8)}, {o_fetch_req, o_fetch_addr})
			fdat = (p == 0) ? 64'h8000_0000_0000_0001 : 64'h0;
			ack = 1'b1;
			@(negedge clk);
			ack = 1'b0;
			fdat = ~fdat;
		end
	endtask

	task automatic nofetch(input logic [11:0] y);
		pulse(1'b0, y);
		repeat (4) @(negedge clk);
		`CHK("no_fetch", 1'b0, o_fetch_req)
	endtask

	task automatic report_and_stop;
		if (err_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		#(40 * 4000);
		err_count++;
		report_and_stop();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		rst = 1'b1;
		req = '0;
		frm = 1'b0;
		lin = 1'b0;
		ly = 12'h000;
		base = 14'h0012;
		ack = 1'b0;
		fdat = 64'h0;
		pix = '0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		rd(1'b0, OFF_PWR_RES, 8'h00, "ctl0_rst");
		rd(1'b1, LEG_PIX_MASK, 8'h00, "mask_rst");
		wr(1'b0, 1'b0, OFF_PWR_RES, 24'h000006);
		rd(1'b0, OFF_PWR_RES, 8'h06, "ctl0");
		rd(1'b0, OFF_PIXMODE, 8'h00, "ctl1_rst");
		rd(1'b0, OFF_CUR_IDX, 8'h00, "ctl2_rst");
		// Fast load, then byte reads through the legacy read index
		wr(1'b1, 1'b0, LEG_PAL_WR_IDX, 24'h000005);
		wr(1'b0, 1'b1, OFF_PAL_DATA, 24'h112233);
		rd(1'b0, OFF_PAL_WR_IDX, 8'h06, "wr_idx_word");
		wr(1'b1, 1'b0, LEG_STATE, 24'h000005);
		rd(1'b0, OFF_PAL_RD_IDX, 8'h05, "rd_idx_legacy");
		rd(1'b0, OFF_PAL_DATA, 8'h11, "pal_r");
		rd(1'b0, OFF_PAL_DATA, 8'h22, "pal_g");
		rd(1'b1, LEG_PAL_DATA, 8'h33, "pal_b");
		rd(1'b1, LEG_STATE, LEG_OP_READ, "leg_rd");
		rd(1'b0, OFF_LAST_DIR, 8'h01, "dir_rd");
		rd(1'b0, OFF_STATE_RPT, {STATUS_ID, STATUS_REV, 2'b01, COMP_RED},
			"stat_rd");
		wr(1'b0, 1'b0, OFF_STATE_RPT, 24'h0000FF);
		rd(1'b0, OFF_STATE_RPT, {STATUS_ID, STATUS_REV, 2'b01, COMP_RED},
			"stat_ro");
		wr(1'b0, 1'b0, OFF_PAL_DATA, 24'h0000AA);
		rd(1'b0, OFF_STATE_RPT, {STATUS_ID, STATUS_REV, 2'b00, COMP_GREEN},
			"stat_wr");
		rd(1'b0, OFF_LAST_DIR, 8'h00, "dir_wr");
		rd(1'b1, LEG_STATE, LEG_OP_WRITE, "leg_wr");
		wr(1'b0, 1'b0, OFF_PAL_DATA, 24'h0000BB);
		wr(1'b0, 1'b0, OFF_PAL_DATA, 24'h0000CC);
		rd(1'b0, OFF_PAL_WR_IDX, 8'h07, "wr_idx_byte");
		rd(1'b0, 10'h0C0, 8'h00, "unmapped");
		wr(1'b1, 1'b0, LEG_PIX_MASK, 24'h0000FF);
		rd(1'b0, OFF_PIX_MASK, 8'hFF, "mask");
		// Pixel modes, bypass, resolution and power-down
		wr(1'b0, 1'b0, OFF_PIXMODE, 24'h000040);
		rd(1'b0, OFF_PIXMODE, 8'h40, "ctl1");
		px(12'h010, 24'h000005, 24'h112233, "pix8_a");
		px(12'h011, 24'h000006, 24'hAABBCC, "pix8_b");
		wr(1'b0, 1'b0, OFF_PIXMODE, 24'h000000);
		px(12'h015, 24'h050605, 24'h11BB33, "pix32");
		wr(1'b0, 1'b0, OFF_PIXMODE, 24'h000010);
		px(12'h012, 24'hABCDEF, 24'hABCDEF, "bypass");
		wr(1'b0, 1'b0, OFF_PIXMODE, 24'h000040);
		wr(1'b0, 1'b0, OFF_PWR_RES, 24'h000004);
		px(12'h013, 24'h000005, 24'h4488CC, "res6");
		wr(1'b0, 1'b0, OFF_PWR_RES, 24'h000005);
		px(12'h014, 24'h000005, 24'h000000, "pwr_down");
		wr(1'b0, 1'b0, OFF_PWR_RES, 24'h000006);
		// Cursor colour 1, then position staged but not committed
		wr(1'b0, 1'b0, OFF_CC_WR_IDX, 24'h000001);
		wr(1'b0, 1'b0, OFF_CC_DATA, 24'h0000C1);
		wr(1'b0, 1'b0, OFF_CC_DATA, 24'h0000C2);
		wr(1'b0, 1'b0, OFF_CC_DATA, 24'h0000C3);
		wr(1'b0, 1'b0, OFF_CUR_IDX, 24'h000007);
		rd(1'b0, OFF_CUR_IDX, 8'h07, "ctl2");
		wr(1'b0, 1'b0, OFF_CUR_IDX, 24'h000001);
		wr(1'b0, 1'b0, OFF_CUR_X_LO, 24'h000000);
		wr(1'b0, 1'b0, OFF_CUR_X_HI, 24'h000001);
		wr(1'b0, 1'b0, OFF_CUR_Y_LO, 24'h0000C0);
		// A leaked staged Y of 192 would hit line 128
		pulse(1'b1, 12'h000);
		nofetch(12'd128);
		// Committed mid-frame: the frame keeps the hidden position
		wr(1'b0, 1'b0, OFF_CUR_Y_HI, 24'h000001);
		nofetch(12'd384);
		pulse(1'b1, 12'h000);
		pulse(1'b0, 12'd384);
		fetch(24'h004800 + 24'd1008, "top_line");
		px(12'd192, 24'h000005, 24'hC1C2C3, "cur_left");
		px(12'd193, 24'h000005, 24'h112233, "cur_next");
		wr(1'b0, 1'b0, OFF_CUR_IDX, 24'h000003);
		px(12'd192, 24'h000005, 24'h112233, "cur_xwin");
		wr(1'b0, 1'b0, OFF_CUR_IDX, 24'h000001);
		fetch_bottom();
		report_and_stop();
	end

	task automatic fetch_bottom;
		pulse(1'b0, 12'd447);
		fetch(24'h004800, "bottom_line");
		// Position (1,1): bottom-right cursor pixel on display pixel 0
		wr(1'b0, 1'b0, OFF_CUR_X_LO, 24'h000001);
		wr(1'b0, 1'b0, OFF_CUR_X_HI, 24'h000000);
		wr(1'b0, 1'b0, OFF_CUR_Y_LO, 24'h000001);
		wr(1'b0, 1'b0, OFF_CUR_Y_HI, 24'h000000);
		pulse(1'b1, 12'h000);
		pulse(1'b0, 12'h000);
		fetch(24'h004800, "corner_line");
		px(12'h000, 24'h000005, 24'hC1C2C3, "cur_corner");
		px(12'h001, 24'h000005, 24'h112233, "cur_beyond");
		wr(1'b0, 1'b0, OFF_CUR_X_LO, 24'h000000);
		wr(1'b0, 1'b0, OFF_CUR_Y_LO, 24'h000000);
		wr(1'b0, 1'b0, OFF_CUR_Y_HI, 24'h000000);
		pulse(1'b1, 12'h000);
		nofetch(12'h000);
	endtask
endmodule
